// *** design/psr4_map.svh ***
`ifndef PSR4_MAP_SVH
`define PSR4_MAP_SVH

// register width and reset contents
`define PSR4_WIDTH      4
`define PSR4_RESET_VAL  4'h0

// first-stage control encoding {set, clear_inv}
`define PSR4_FS_CLEAR   2'h0
`define PSR4_FS_HOLD    2'h1
`define PSR4_FS_TOGGLE  2'h2
`define PSR4_FS_SET     2'h3

`endif

// *** design/psr4_pkg.sv ***
package psr4_pkg;

    // inputs sampled just before a shift clock edge
    typedef struct packed {
        logic       shift_not_load_select;
        logic       first_set;
        logic       first_clear_inv;
        logic [3:0] parallel_in;
    } psr4_ctrl_type;

endpackage : psr4_pkg

// *** design/psr4_sync.sv ***
`timescale 1ns/1ps
// two-flop synchroniser for a group of pin inputs
module psr4_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             sys_clk_i,
    input  wire logic             rst_i,
    input  wire logic             clk_en_i,
    // pins
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta;

    // first flop is read only by the second
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            meta   <= '0;
            sync_o <= '0;
        end
        else if (clk_en_i)
        begin
            meta   <= async_i;
            sync_o <= meta;
        end
    end
endmodule : psr4_sync

// *** design/psr4_shift_reg.sv ***
`timescale 1ns/1ps
`include "psr4_map.svh"
// Contract
// - clear low forces all stages low and inverted last stage high, overriding all
// - shift with set and clear_inv high: stage 0 set, others shift
// - shift with both low: stage 0 cleared, others shift
// - shift with set high, clear_inv low: stage 0 toggles, others shift
// - shift with set low, clear_inv high: stage 0 holds, others shift
// - inputs sampled before rising shift clock edge; outputs change only then or when clear goes low
// - load mode copies parallel inputs into stages, ignoring serial controls
module psr4_shift_reg
    import psr4_pkg::*;
#(
    parameter int WIDTH = `PSR4_WIDTH
) (
    // system clock, reset, enable
    input  wire logic             sys_clk_i,
    input  wire logic             rst_i,
    input  wire logic             clk_en_i,
    // device pins
    input  wire logic             shift_clock_in_i,
    input  wire logic             async_clear_n_i,
    input  wire logic             shift_not_load_select_i,
    input  wire logic             first_set_i,
    input  wire logic             first_clear_inv_i,
    input  wire logic [WIDTH-1:0] parallel_in_i,
    // stage outputs
    output logic      [WIDTH-1:0] stage_out_o,
    output logic                  last_stage_out_inv_o
);
    localparam int SW = WIDTH + 5;

    logic [SW-1:0]    sync_bus;
    logic [WIDTH-1:0] stage;
    logic [WIDTH-1:0] next_stage;
    logic             clk_d;
    logic             clk_rise;
    logic             clear_n_s;
    psr4_ctrl_type    ctrl;

    // every pin is outside this clock domain
    psr4_sync #(
        .WIDTH (SW)
    ) u_sync (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .clk_en_i  (clk_en_i),
        .async_i   ({shift_clock_in_i, async_clear_n_i, shift_not_load_select_i,
                     first_set_i, first_clear_inv_i, parallel_in_i}),
        .sync_o    (sync_bus)
    );

    // unpack synchronised pins; data travel in step with the clock pin
    assign clear_n_s                  = sync_bus[SW-2];
    assign ctrl.shift_not_load_select = sync_bus[SW-3];
    assign ctrl.first_set             = sync_bus[SW-4];
    assign ctrl.first_clear_inv       = sync_bus[SW-5];
    assign ctrl.parallel_in           = sync_bus[WIDTH-1:0];

    // edge detect on the synchronised shift clock
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
            clk_d <= 1'b0;
        else if (clk_en_i)
            clk_d <= sync_bus[SW-1];
    end

    // clk_d keeps tracking the clock during clear, so a clear release while the clock is high is not seen as an edge
    assign clk_rise = sync_bus[SW-1] & ~clk_d;

    // next value from the state just before the edge
    always_comb
    begin
        next_stage = stage;
        if (!ctrl.shift_not_load_select)
            next_stage = ctrl.parallel_in;
        else
        begin
            next_stage = {stage[WIDTH-2:0], stage[0]};
            unique case ({ctrl.first_set, ctrl.first_clear_inv})
                `PSR4_FS_SET:    next_stage[0] = 1'b1;
                `PSR4_FS_CLEAR:  next_stage[0] = 1'b0;
                `PSR4_FS_TOGGLE: next_stage[0] = ~stage[0];
                `PSR4_FS_HOLD:   next_stage[0] = stage[0];
            endcase
        end
    end

    // stages move only on a detected edge; clear overrides everything
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
            stage <= `PSR4_RESET_VAL;
        else if (clk_en_i)
        begin
            if (!clear_n_s)
                stage <= `PSR4_RESET_VAL;
            else if (clk_rise)
                stage <= next_stage;
        end
    end

    // clear gated combinationally so outputs fall without waiting for a pin edge
    assign stage_out_o          = clear_n_s ? stage : `PSR4_RESET_VAL;
    assign last_stage_out_inv_o = ~stage_out_o[WIDTH-1];

endmodule : psr4_shift_reg

// *** bench/psr4_checker.sv ***
`timescale 1ns/1ps
module psr4_checker (
    input wire logic       sys_clk_i, rst_i, shift_clock_in_i, async_clear_n_i, shift_not_load_select_i,
    input wire logic       first_set_i, first_clear_inv_i, last_stage_out_inv_o,
    input wire logic [3:0] parallel_in_i, stage_out_o
);
    // a pin rise is seen on the 3rd edge after its first sample, behind the sync flops
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    inv_track_a:
        assert property (last_stage_out_inv_o != stage_out_o[3]) else $error("inv");
    load_copy_a:
        assert property ($rose(shift_clock_in_i) && !shift_not_load_select_i && async_clear_n_i
            |-> ##3 stage_out_o == $past(parallel_in_i, 3)) else $error("load");
    shift_step_a:
        assert property ($rose(shift_clock_in_i) && shift_not_load_select_i && async_clear_n_i |-> ##3
            stage_out_o == {$past(stage_out_o[2:0]), $past(first_set_i, 3) && !$past(stage_out_o[0])
            || $past(first_clear_inv_i, 3) && $past(stage_out_o[0])}) else $error("shift");
    edge_only_a:
        assert property ($stable(shift_clock_in_i) [*4] |-> $stable(stage_out_o) || !stage_out_o) else $error("edge");
    clear_force_a:
        assert property (!async_clear_n_i |-> ##2 stage_out_o == 4'h0 && last_stage_out_inv_o) else $error("clear");
    toggle_first_a:
        assert property ($rose(shift_clock_in_i) && shift_not_load_select_i && first_set_i && !first_clear_inv_i
            && async_clear_n_i |-> ##3 stage_out_o[0] != $past(stage_out_o[0])) else $error("toggle");
endmodule : psr4_checker
bind psr4_shift_reg psr4_checker chk (.*);

// *** bench/psr4_host.sv ***
`timescale 1ns/1ps
module psr4_host (
    input  wire logic  sys_clk_i,
    output logic       shift_clock_in_i = 1'b0, async_clear_n_i = 1'b1, shift_not_load_select_i = 1'b0,
    output logic       first_set_i = 1'b0, first_clear_inv_i = 1'b0,
    output logic [3:0] parallel_in_i = 4'h0
);
    // inputs settle 2 cycles before the rise; ends low so clear release is safe
    task automatic pulse(input logic [6:0] v);
        {shift_not_load_select_i, first_set_i, first_clear_inv_i, parallel_in_i} = v;
        repeat (2) @(posedge sys_clk_i) #1;
        shift_clock_in_i = 1'b1;
        repeat (2) @(posedge sys_clk_i) #1;
        shift_clock_in_i = 1'b0;
        repeat (4) @(posedge sys_clk_i) #1;
    endtask : pulse
endmodule : psr4_host

// *** bench/tb.sv ***
`timescale 1ns/1ps
module tb;
    logic       sys_clk_i = 1'b0, rst_i = 1'b1, shift_clock_in_i, async_clear_n_i, shift_not_load_select_i;
    logic       first_set_i, first_clear_inv_i, last_stage_out_inv_o;
    logic [3:0] parallel_in_i, stage_out_o;
    int         error_cnt = 0, checks_done = 0, cyc = 0;
    always #25 sys_clk_i = ~sys_clk_i;
    psr4_host host (.*);
    psr4_shift_reg dut (.*, .clk_en_i(1'b1));
    // stages and inverted last stage against e
    task automatic chk(input logic [3:0] e);
        checks_done++;
        if ({last_stage_out_inv_o, stage_out_o} !== {~e[3], e})
        begin
            error_cnt++;
            $display("[ERR] %0t %h %h", $time, {last_stage_out_inv_o, stage_out_o}, {~e[3], e});
        end
    endtask : chk
    task automatic test_done();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : test_done
    // load with serial pair high, then all four first-stage codes from 1001
    task automatic t_shift();
        logic [5:0] s [4] = '{6'h33, 6'h06, 6'h2D, 6'h1B};
        host.pulse(7'h39);
        chk(4'h9);
        foreach (s[i])
        begin
            host.pulse({1'b1, s[i][5:4], 4'h0});
            chk(s[i][3:0]);
        end
    endtask : t_shift
    // a clock during clear is lost; idle load inputs change nothing
    task automatic t_clear();
        host.async_clear_n_i = 1'b0;
        host.pulse(7'h3F);
        chk(4'h0);
        host.async_clear_n_i = 1'b1;
        repeat (6) @(posedge sys_clk_i) #1;
        chk(4'h0);
    endtask : t_clear
    // whole run is near 60 cycles
    always @(posedge sys_clk_i)
        if (++cyc == 1000)
        begin
            error_cnt++;
            test_done();
        end
    initial
    begin
        repeat (5) @(posedge sys_clk_i) #1;
        rst_i = 1'b0;
        t_shift();
        t_clear();
        test_done();
    end
endmodule : tb
